// >>> logic/atc_timer.sv
// 8-bit timer/counter with prescaler, oscillator clock option and waveform output
`timescale 1ns/1ps
`default_nettype none
module atc_timer (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire atc_pkg::atc_bus_req_t bus_req,
    output logic [7:0] rd_data,
    input wire atc_pkg::atc_irq_in_t irq_in,
    input wire logic osc_pin_in,
    output logic osc_pins_detached,
    output logic compare_output_pin,
    output logic compare_irq_req,
    output logic overflow_irq_req
);
    import atc_pkg::*;

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [7:0] counter_value;
        logic [7:0] compare_value;
        logic [7:0] compare_buffer;
        logic [2:0] clk_sel;
        atc_mode_t mode;
        atc_out_mode_t out_mode;
        logic async_clock_select;
        logic [PRESCALER_WIDTH-1:0] prescaler;
        logic prescaler_reset_bit;
        logic compare_irq_enable;
        logic overflow_irq_enable;
        logic compare_match_flag;
        logic overflow_flag;
        logic count_down;
        logic wave;
        logic [2:0] osc_sync;
        logic [7:0] rd_data;
        logic compare_irq;
        logic overflow_irq;
    } atc_state_t;

    atc_state_t st;
    atc_state_t next_st;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Prescaler low bits that must all be one for a divided tick
    function automatic logic [PRESCALER_WIDTH-1:0] divide_mask(input logic [2:0] sel);
        case (sel)
            3'h2: divide_mask = 10'h007;
            3'h3: divide_mask = 10'h01f;
            3'h4: divide_mask = 10'h03f;
            3'h5: divide_mask = 10'h07f;
            3'h6: divide_mask = 10'h0ff;
            3'h7: divide_mask = 10'h3ff;
            default: divide_mask = 10'h000;
        endcase
    endfunction : divide_mask

    function automatic logic is_pwm(input atc_mode_t m);
        is_pwm = (m == ATC_MODE_PWM_PHASE) || (m == ATC_MODE_PWM_FAST);
    endfunction : is_pwm

    logic source_tick;
    logic timer_tick;
    logic [7:0] top_value;
    logic match_now;
    logic overflow_now;
    logic at_top;

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    always_comb begin
        next_st = st;

        // Only the second and third stages feed the edge detector
        next_st.osc_sync = {st.osc_sync[1:0], osc_pin_in};
        source_tick = st.async_clock_select ? (st.osc_sync[1] & ~st.osc_sync[2]) : 1'b1;

        // Prescaler runs freely on source ticks
        if (source_tick) begin
            next_st.prescaler = st.prescaler + 10'h001;
        end
        timer_tick = source_tick && (st.clk_sel != 3'h0) &&
            ((st.prescaler & divide_mask(st.clk_sel)) == divide_mask(st.clk_sel));

        // Prescaler reset: immediate when synchronous, on next oscillator edge otherwise
        if (st.prescaler_reset_bit && (!st.async_clock_select || source_tick)) begin
            next_st.prescaler = '0;
            next_st.prescaler_reset_bit = 1'b0;
        end

        top_value = (st.mode == ATC_MODE_CLEAR_ON_MATCH) ? st.compare_buffer : COUNT_MAX;
        at_top = (st.counter_value == top_value);
        match_now = 1'b0;
        overflow_now = 1'b0;

        if (timer_tick) begin
            match_now = (st.counter_value == st.compare_buffer);
            case (st.mode)
                ATC_MODE_PWM_PHASE: begin
                    if (!st.count_down) begin
                        if (st.counter_value == COUNT_MAX) begin
                            next_st.count_down = 1'b1;
                            next_st.counter_value = st.counter_value - 8'h01;
                            next_st.compare_buffer = st.compare_value;
                        end else begin
                            next_st.counter_value = st.counter_value + 8'h01;
                        end
                    end else if (st.counter_value == COUNT_BOTTOM) begin
                        // Direction turns at bottom and that is the overflow
                        next_st.count_down = 1'b0;
                        next_st.counter_value = st.counter_value + 8'h01;
                        overflow_now = 1'b1;
                    end else begin
                        next_st.counter_value = st.counter_value - 8'h01;
                    end
                end
                ATC_MODE_PWM_FAST: begin
                    next_st.count_down = 1'b0;
                    next_st.counter_value = st.counter_value + 8'h01;
                    if (at_top) begin
                        overflow_now = 1'b1;
                        next_st.compare_buffer = st.compare_value;
                    end
                end
                ATC_MODE_CLEAR_ON_MATCH: begin
                    next_st.count_down = 1'b0;
                    if (at_top) begin
                        next_st.counter_value = COUNT_BOTTOM;
                    end else begin
                        next_st.counter_value = st.counter_value + 8'h01;
                    end
                    overflow_now = (st.counter_value == COUNT_MAX);
                end
                default: begin
                    next_st.count_down = 1'b0;
                    next_st.counter_value = st.counter_value + 8'h01;
                    overflow_now = (st.counter_value == COUNT_MAX);
                end
            endcase

            // Waveform generator
            case (st.mode)
                ATC_MODE_PWM_FAST: begin
                    if (match_now) begin
                        next_st.wave = (st.out_mode == ATC_OUT_SET);
                    end else if (at_top) begin
                        next_st.wave = (st.out_mode != ATC_OUT_SET);
                    end
                end
                ATC_MODE_PWM_PHASE: begin
                    if (match_now) begin
                        next_st.wave = (st.out_mode == ATC_OUT_SET) ^ st.count_down;
                    end
                end
                default: begin
                    if (match_now) begin
                        case (st.out_mode)
                            ATC_OUT_TOGGLE: next_st.wave = ~st.wave;
                            ATC_OUT_CLEAR: next_st.wave = 1'b0;
                            ATC_OUT_SET: next_st.wave = 1'b1;
                            default: next_st.wave = st.wave;
                        endcase
                    end
                end
            endcase
        end

        // Non-PWM modes load the compare value straight through
        if (!is_pwm(st.mode)) begin
            next_st.compare_buffer = st.compare_value;
        end

        // Flag clears first so that a coincident set wins
        if (irq_in.vector_compare) begin
            next_st.compare_match_flag = 1'b0;
        end
        if (irq_in.vector_overflow) begin
            next_st.overflow_flag = 1'b0;
        end

        // Register writes
        next_st.rd_data = REG_RESET;
        if (bus_req.wr) begin
            case (bus_req.addr)
                ADDR_COUNTER_VALUE: next_st.counter_value = bus_req.wdata;
                ADDR_COMPARE_VALUE: next_st.compare_value = bus_req.wdata;
                ADDR_TIMER_CONTROL: begin
                    next_st.clk_sel = bus_req.wdata[CTRL_CLK_SEL_LSB +: 3];
                    next_st.mode = atc_mode_t'(bus_req.wdata[CTRL_MODE_LSB +: 2]);
                    next_st.out_mode = atc_out_mode_t'(bus_req.wdata[CTRL_OUT_MODE_LSB +: 2]);
                end
                ADDR_ASYNC_STATUS: next_st.async_clock_select = bus_req.wdata[ASYNC_SELECT_BIT];
                ADDR_TIMER_IRQ_MASK: begin
                    next_st.compare_irq_enable = bus_req.wdata[COMPARE_BIT];
                    next_st.overflow_irq_enable = bus_req.wdata[OVERFLOW_BIT];
                end
                ADDR_TIMER_IRQ_FLAGS: begin
                    if (bus_req.wdata[COMPARE_BIT]) begin
                        next_st.compare_match_flag = 1'b0;
                    end
                    if (bus_req.wdata[OVERFLOW_BIT]) begin
                        next_st.overflow_flag = 1'b0;
                    end
                end
                ADDR_SPECIAL_FUNCTION_IO: begin
                    // Writing zero leaves a pending reset alone
                    if (bus_req.wdata[PRESCALER_RESET_BIT]) begin
                        next_st.prescaler_reset_bit = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end

        // Hardware sets override any clear in the same cycle
        if (match_now) begin
            next_st.compare_match_flag = 1'b1;
        end
        if (overflow_now) begin
            next_st.overflow_flag = 1'b1;
        end

        // Register reads, answered one cycle later
        if (bus_req.rd) begin
            case (bus_req.addr)
                ADDR_COUNTER_VALUE: next_st.rd_data = st.counter_value;
                ADDR_COMPARE_VALUE: next_st.rd_data = st.compare_value;
                ADDR_TIMER_CONTROL: begin
                    next_st.rd_data[CTRL_CLK_SEL_LSB +: 3] = st.clk_sel;
                    next_st.rd_data[CTRL_MODE_LSB +: 2] = st.mode;
                    next_st.rd_data[CTRL_OUT_MODE_LSB +: 2] = st.out_mode;
                end
                ADDR_ASYNC_STATUS: next_st.rd_data[ASYNC_SELECT_BIT] = st.async_clock_select;
                ADDR_TIMER_IRQ_MASK: begin
                    next_st.rd_data[COMPARE_BIT] = st.compare_irq_enable;
                    next_st.rd_data[OVERFLOW_BIT] = st.overflow_irq_enable;
                end
                ADDR_TIMER_IRQ_FLAGS: begin
                    next_st.rd_data[COMPARE_BIT] = st.compare_match_flag;
                    next_st.rd_data[OVERFLOW_BIT] = st.overflow_flag;
                end
                ADDR_SPECIAL_FUNCTION_IO:
                    next_st.rd_data[PRESCALER_RESET_BIT] = st.async_clock_select & st.prescaler_reset_bit;
                default: next_st.rd_data = REG_RESET;
            endcase
        end

        // Interrupt requests, gated by enable and global enable
        next_st.compare_irq = st.compare_irq_enable & irq_in.global_enable & st.compare_match_flag;
        next_st.overflow_irq = st.overflow_irq_enable & irq_in.global_enable & st.overflow_flag;
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign compare_irq_req = st.compare_irq;
    assign overflow_irq_req = st.overflow_irq;
    assign compare_output_pin = st.wave;
    assign osc_pins_detached = st.async_clock_select;

endmodule : atc_timer
`default_nettype wire

// >>> logic/atc_pkg.sv
// Constants, register map and state types of the 8-bit asynchronous-capable timer
package atc_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [2:0] ADDR_COUNTER_VALUE = 3'h0;
    localparam logic [2:0] ADDR_COMPARE_VALUE = 3'h1;
    localparam logic [2:0] ADDR_TIMER_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_ASYNC_STATUS = 3'h3;
    localparam logic [2:0] ADDR_TIMER_IRQ_MASK = 3'h4;
    localparam logic [2:0] ADDR_TIMER_IRQ_FLAGS = 3'h5;
    localparam logic [2:0] ADDR_SPECIAL_FUNCTION_IO = 3'h6;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int CTRL_CLK_SEL_LSB = 0;
    localparam int CTRL_MODE_LSB = 3;
    localparam int CTRL_OUT_MODE_LSB = 5;
    localparam int ASYNC_SELECT_BIT = 3;
    localparam int COMPARE_BIT = 7;
    localparam int OVERFLOW_BIT = 6;
    localparam int PRESCALER_RESET_BIT = 1;

    // ----------------------------------------------------------------
    // Counter limits, reset values and prescaler width
    // ----------------------------------------------------------------
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int PRESCALER_WIDTH = 10;

    // ----------------------------------------------------------------
    // Encodings
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ATC_MODE_NORMAL,
        ATC_MODE_PWM_PHASE,
        ATC_MODE_CLEAR_ON_MATCH,
        ATC_MODE_PWM_FAST
    } atc_mode_t;

    typedef enum logic [1:0] {
        ATC_OUT_OFF,
        ATC_OUT_TOGGLE,
        ATC_OUT_CLEAR,
        ATC_OUT_SET
    } atc_out_mode_t;

    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } atc_bus_req_t;

    typedef struct packed {
        logic vector_compare;
        logic vector_overflow;
        logic global_enable;
    } atc_irq_in_t;

endpackage : atc_pkg

// >>> tb/atc_timer_assertions.sv
// Concurrent checks on the timer ports, bound onto the design
`timescale 1ns/1ps
`default_nettype none
module atc_timer_assertions (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire atc_pkg::atc_bus_req_t bus_req,
    input wire logic [7:0] rd_data,
    input wire atc_pkg::atc_irq_in_t irq_in,
    input wire logic osc_pin_in,
    input wire logic osc_pins_detached,
    input wire logic compare_output_pin,
    input wire logic compare_irq_req,
    input wire logic overflow_irq_req
);
    import atc_pkg::*;
    // ----------------------------------------------------------------
    // Shadows of software-written fields
    // ----------------------------------------------------------------
    logic [7:0] mask_sh;
    logic [7:0] ctrl_sh;
    logic async_sh;
    logic stopped;
    logic w_mask;
    logic w_ctrl;
    logic w_async;
    assign w_mask = bus_req.wr && (bus_req.addr == ADDR_TIMER_IRQ_MASK);
    assign w_ctrl = bus_req.wr && (bus_req.addr == ADDR_TIMER_CONTROL);
    assign w_async = bus_req.wr && (bus_req.addr == ADDR_ASYNC_STATUS);
    // With no clock selected no flag can be set, so clears are observable
    assign stopped = (ctrl_sh[2:0] == 3'h0);
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            mask_sh <= 8'h00;
            ctrl_sh <= 8'h00;
            async_sh <= 1'b0;
        end else begin
            mask_sh <= w_mask ? bus_req.wdata : mask_sh;
            ctrl_sh <= w_ctrl ? bus_req.wdata : ctrl_sh;
            async_sh <= w_async ? bus_req.wdata[ASYNC_SELECT_BIT] : async_sh;
        end
    end
    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking dcb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);
    a_cmp_irq_gate: assert property (compare_irq_req |-> $past(mask_sh[7] && irq_in.global_enable))
        else $error("compare request without its enables");
    a_ovf_irq_gate: assert property (overflow_irq_req |-> $past(mask_sh[6] && irq_in.global_enable))
        else $error("overflow request without its enables");
    a_mask_readback: assert property ($past(bus_req.rd && bus_req.addr == ADDR_TIMER_IRQ_MASK)
        |-> rd_data == {$past(mask_sh[7:6]), 6'h00}) else $error("mask readback wrong");
    a_ctrl_readback: assert property ($past(bus_req.rd && bus_req.addr == ADDR_TIMER_CONTROL)
        |-> rd_data == {1'b0, $past(ctrl_sh[6:0])}) else $error("control readback wrong");
    a_flags_reserved: assert property ($past(bus_req.rd && bus_req.addr == ADDR_TIMER_IRQ_FLAGS)
        |-> rd_data[5:0] == 6'h00) else $error("flag register low bits not zero");
    a_psr_sync_zero: assert property ($past(bus_req.rd && bus_req.addr == ADDR_SPECIAL_FUNCTION_IO && !async_sh)
        |-> rd_data == 8'h00) else $error("prescaler reset bit read as one while synchronous");
    a_pins_detach: assert property (async_sh && $past(async_sh) |-> osc_pins_detached)
        else $error("oscillator pins not detached");
    a_pins_attach: assert property (!async_sh && !$past(async_sh) |-> !osc_pins_detached)
        else $error("oscillator pins detached without async select");
    a_ovf_vec_clear: assert property ((irq_in.vector_overflow && stopped) ##1 stopped |-> ##1 !overflow_irq_req)
        else $error("overflow request kept after vector");
    a_cmp_wr_clear: assert property ((bus_req.wr && bus_req.addr == ADDR_TIMER_IRQ_FLAGS
        && bus_req.wdata[7] && stopped) ##1 stopped |-> ##1 !compare_irq_req) else $error("compare flag not cleared");
    c_ovf_req: cover property ($rose(overflow_irq_req));
    c_cmp_req: cover property ($rose(compare_irq_req));
    c_detach: cover property ($rose(osc_pins_detached));
endmodule : atc_timer_assertions
bind atc_timer atc_timer_assertions chk_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
    .irq_in(irq_in), .osc_pin_in(osc_pin_in), .osc_pins_detached(osc_pins_detached),
    .compare_output_pin(compare_output_pin), .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req));
`default_nettype wire

// >>> tb/atc_timer_tb_top.sv
// Self-checking testbench for the 8-bit timer
`timescale 1ns/1ps
`default_nettype none
module atc_timer_tb_top;
    import atc_pkg::*;
    logic ref_clk;
    logic rst_n;
    atc_bus_req_t bus_req;
    logic [7:0] rd_data;
    atc_irq_in_t irq_in;
    logic osc_pin_in;
    logic osc_pins_detached;
    logic compare_output_pin;
    logic compare_irq_req;
    logic overflow_irq_req;
    int num_errors = 0;
    int n_checks = 0;
    int seed = 32'h1391;
    int dtab[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [2:0] atab[3] = '{ADDR_COUNTER_VALUE, ADDR_COMPARE_VALUE, ADDR_TIMER_IRQ_MASK};
    logic [2:0] a;
    logic [7:0] v;
    logic [3:0] o;
    logic p;
    atc_timer dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data), .irq_in(irq_in),
        .osc_pin_in(osc_pin_in), .osc_pins_detached(osc_pins_detached), .compare_output_pin(compare_output_pin),
        .compare_irq_req(compare_irq_req), .overflow_irq_req(overflow_irq_req));
    // ----------------------------------------------------------------
    // Bus, compare and verdict tasks
    // ----------------------------------------------------------------
    function automatic logic [7:0] cw(input int om, input int m, input int s);
        return 8'((om << CTRL_OUT_MODE_LSB) | (m << CTRL_MODE_LSB) | s);
    endfunction : cw
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk8
    // Each task assigns the whole request in every assignment, so back-to-back calls never double-drive a strobe
    task automatic wr(input logic [2:0] ad, input logic [7:0] d);
        bus_req <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge ref_clk);
    endtask : wr
    task automatic idle(input int n);
        bus_req <= '0;
        repeat (n) @(posedge ref_clk);
    endtask : idle
    task automatic rd(input logic [2:0] ad, output logic [7:0] d);
        bus_req <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge ref_clk);
        bus_req <= '0;
        @(negedge ref_clk);
        d = rd_data;
        @(posedge ref_clk);
    endtask : rd
    task automatic rchk(input logic [2:0] ad, input logic [7:0] e);
        rd(ad, v);
        chk8(v, e);
    endtask : rchk
    // Outputs are sampled mid-cycle so the launching edge has settled
    task automatic outs();
        @(negedge ref_clk);
        o = {compare_output_pin, osc_pins_detached, compare_irq_req, overflow_irq_req};
        @(posedge ref_clk);
    endtask : outs
    task automatic osc(input int n);
        repeat (n) begin
            osc_pin_in <= 1'b1;
            repeat (4) @(posedge ref_clk);
            osc_pin_in <= 1'b0;
            repeat (4) @(posedge ref_clk);
        end
    endtask : osc
    task automatic print_verdict();
        $display("checks=%0d errors=%0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : print_verdict
    // ----------------------------------------------------------------
    // Clock, watchdog and scenarios
    // ----------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    initial begin
        repeat (30000) @(posedge ref_clk);
        num_errors++;
        print_verdict();
    end
    initial begin
        rst_n = 1'b0;
        bus_req = '0;
        irq_in = '0;
        osc_pin_in = 1'b0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) rchk(3'(i), 8'h00);
        for (int i = 0; i < 12; i++) begin
            a = atab[i % 3];
            v = 8'($random(seed));
            wr(a, v);
            rchk(a, (a == ADDR_TIMER_IRQ_MASK) ? (v & 8'hc0) : v);
        end
        wr(3'h7, 8'hff);
        rchk(3'h7, 8'h00);
        wr(ADDR_COMPARE_VALUE, 8'h80);
        wr(ADDR_COUNTER_VALUE, 8'hfe);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'hc0);
        wr(ADDR_TIMER_IRQ_MASK, 8'hc0);
        wr(ADDR_TIMER_CONTROL, cw(0, 0, 1));
        idle(1);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rchk(ADDR_COUNTER_VALUE, 8'h00);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h40);
        outs();
        chk8({7'h0, o[0]}, 8'h00);
        irq_in.global_enable <= 1'b1;
        idle(2);
        outs();
        chk8({6'h0, o[1], o[0]}, 8'h01);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'h00);
        idle(20);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h40);
        rchk(ADDR_COUNTER_VALUE, 8'h00);
        irq_in.vector_overflow <= 1'b1;
        @(posedge ref_clk);
        irq_in.vector_overflow <= 1'b0;
        idle(2);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h00);
        wr(ADDR_COMPARE_VALUE, 8'h12);
        wr(ADDR_COUNTER_VALUE, 8'h10);
        wr(ADDR_TIMER_CONTROL, cw(0, 0, 1));
        idle(2);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rchk(ADDR_COUNTER_VALUE, 8'h13);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h80);
        outs();
        chk8({7'h0, o[1]}, 8'h01);
        wr(ADDR_TIMER_IRQ_MASK, 8'h40);
        idle(2);
        outs();
        chk8({7'h0, o[1]}, 8'h00);
        // Mask back on, so that only the write-one clear can drop the request
        wr(ADDR_TIMER_IRQ_MASK, 8'hc0);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'h80);
        idle(2);
        outs();
        chk8({7'h0, o[1]}, 8'h00);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h00);
        wr(ADDR_SPECIAL_FUNCTION_IO, 8'h02);
        rchk(ADDR_SPECIAL_FUNCTION_IO, 8'h00);
        for (int s = 1; s < 8; s++) begin
            wr(ADDR_COUNTER_VALUE, 8'h00);
            wr(ADDR_SPECIAL_FUNCTION_IO, 8'h02);
            wr(ADDR_TIMER_CONTROL, cw(0, 0, s));
            idle(4 * dtab[s] + dtab[s] / 2);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rd(ADDR_COUNTER_VALUE, v);
            // Freshly reset prescaler: one tick per full period, the stopping write included
            chk8(v, 8'((4 * dtab[s] + dtab[s] / 2 + 1) / dtab[s]));
        end
        wr(ADDR_COMPARE_VALUE, 8'h03);
        wr(ADDR_COUNTER_VALUE, 8'h00);
        wr(ADDR_TIMER_IRQ_FLAGS, 8'hc0);
        wr(ADDR_TIMER_CONTROL, cw(1, 2, 1));
        idle(9);
        outs();
        p = o[3];
        idle(3);
        outs();
        chk8({7'h0, o[3]}, {7'h0, ~p});
        wr(ADDR_TIMER_CONTROL, cw(3, 2, 1));
        idle(5);
        outs();
        chk8({7'h0, o[3]}, 8'h01);
        wr(ADDR_TIMER_CONTROL, cw(2, 2, 1));
        idle(5);
        outs();
        chk8({7'h0, o[3]}, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_COUNTER_VALUE, v);
        chk8({7'h0, v <= 8'h03}, 8'h01);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h80);
        irq_in.vector_compare <= 1'b1;
        @(posedge ref_clk);
        irq_in.vector_compare <= 1'b0;
        idle(2);
        rchk(ADDR_TIMER_IRQ_FLAGS, 8'h00);
        for (int m = 1; m < 4; m += 2) begin
            wr(ADDR_COUNTER_VALUE, 8'h00);
            wr(ADDR_TIMER_IRQ_FLAGS, 8'hc0);
            wr(ADDR_TIMER_CONTROL, cw(0, m, 1));
            idle(600);
            wr(ADDR_TIMER_CONTROL, 8'h00);
            rd(ADDR_TIMER_IRQ_FLAGS, v);
            chk8({7'h0, v[6]}, 8'h01);
        end
        wr(ADDR_ASYNC_STATUS, 8'h08);
        wr(ADDR_COUNTER_VALUE, 8'h00);
        wr(ADDR_SPECIAL_FUNCTION_IO, 8'h02);
        idle(2);
        outs();
        chk8({7'h0, o[2]}, 8'h01);
        rchk(ADDR_SPECIAL_FUNCTION_IO, 8'h02);
        wr(ADDR_TIMER_CONTROL, cw(0, 0, 1));
        idle(1);
        osc(5);
        idle(6);
        rchk(ADDR_SPECIAL_FUNCTION_IO, 8'h00);
        wr(ADDR_TIMER_CONTROL, 8'h00);
        rd(ADDR_COUNTER_VALUE, v);
        // One count per oscillator rising edge
        chk8(v, 8'h05);
        wr(ADDR_ASYNC_STATUS, 8'h00);
        idle(3);
        outs();
        chk8({7'h0, o[2]}, 8'h00);
        // Reset in mid-run with state set up: everything must come back to zero
        wr(ADDR_ASYNC_STATUS, 8'h08);
        wr(ADDR_COUNTER_VALUE, 8'h5a);
        rst_n <= 1'b0;
        idle(3);
        rst_n <= 1'b1;
        rchk(ADDR_COUNTER_VALUE, 8'h00);
        outs();
        chk8({4'h0, o}, 8'h00);
        print_verdict();
    end
endmodule : atc_timer_tb_top
`default_nettype wire
